// >>> rtl/enc_diag_pkg.sv
package enc_diag_pkg;
    // register offsets (byte addresses on the bus)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RANGE = 8'h04;
    localparam logic [7:0] OFS_UNITS = 8'h08;
    localparam logic [7:0] OFS_LIFE_LIM = 8'h0C;
    localparam logic [7:0] OFS_FAULTS = 8'h10;
    localparam logic [7:0] OFS_OP_STAT = 8'h14;
    localparam logic [7:0] OFS_POS = 8'h18;
    localparam logic [7:0] OFS_VEL = 8'h1C;
    localparam logic [7:0] OFS_RED = 8'h20;
    localparam logic [7:0] OFS_LOG_CNT = 8'h24;
    localparam logic [1:0] LOG_REGION = 2'h1;
    // control word fields
    localparam int CTL_CLASS4 = 0;
    localparam int CTL_SCALE = 1;
    localparam int CTL_NOCOMPAT = 2;
    localparam int CTL_ALARM = 3;
    localparam int CTL_VEL_LSB = 4;
    localparam int CTL_TEL_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_5101;
    // telegram numbers
    localparam logic [7:0] TEL_VEL_FIRST = 8'h52;
    localparam logic [7:0] TEL_VEL_LAST = 8'h54;
    // parameter limits and defaults
    localparam logic [7:0] LIFE_LIM_RESET = 8'h01;
    localparam logic [7:0] LIFE_LIM_MIN = 8'h01;
    localparam int RANGE_MIN = 2;
    localparam int UNITS_MIN = 1;
    // fault bits; warnings are never implemented
    localparam int FLT_LIFE = 0;
    localparam int FLT_SYNC = 1;
    localparam int FLT_MEM = 2;
    localparam int FLT_PARAM = 3;
    localparam int FLT_W = 4;
    localparam logic [3:0] FLT_SUPPORTED = 4'hF;
    localparam logic [3:0] WARN_SUPPORTED = 4'h0;
    // codes for the second position word
    localparam logic [15:0] ERR_LIFE = 16'h0F02;
    localparam logic [15:0] ERR_SYNC = 16'h0F04;
    localparam logic [15:0] ERR_MEM = 16'h1001;
    localparam logic [15:0] ERR_PARAM = 16'h1002;
    // channel diagnosis error types
    localparam logic [15:0] ALM_MEM = 16'h9000;
    localparam logic [15:0] ALM_PARAM = 16'h9011;
    // velocity timing and unit factors
    localparam int VEL_PERIOD_MS = 100;
    localparam int CLK_KHZ = 125000;
    localparam int VEL_DEFAULT_CYCLES = VEL_PERIOD_MS * CLK_KHZ;
    localparam int VEL_PER_S_MUL = 10;
    localparam int VEL_10MS_DIV = 10;
    localparam int VEL_RPM_MUL = 600;
    typedef enum logic [1:0] {
        VU_STEPS_S, VU_STEPS_100MS, VU_STEPS_10MS, VU_RPM
    } vel_unit_t;
    typedef enum logic {DV_LOAD, DV_RUN} div_state_t;
endpackage : enc_diag_pkg

// >>> rtl/diag_log_mem.sv
`timescale 1ns/1ns
// small record store for diagnosis entries, registered read data
module diag_log_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH]; // entries, no reset needed

    // write port
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, one cycle latency
    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end
endmodule : diag_log_mem

// >>> rtl/enc_scale_diag.sv
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - total range limited to 2..physical, default physical
// - range ignored while scaling control off
// - non power-of-two revolutions give red zone
// - life-sign failure limit 1..255, default 1
// - life-sign limit honoured only in compatibility mode
// - velocity unit codes 0..3, default steps/s
// - velocity only on telegrams 82..84
// - velocity recomputed every 100 ms
// - red zone = physical mod set range
// - position jumps to zero past red zone
// - diagnosis log delivered only as acyclic record reads
// - alarms sent toward controller on alarm port
// - fault raised when position may be wrong
// - warnings never raised
// - readable operating status with support bits
// - memory and parameter faults reported as channel diagnosis by type
// - alarm types 0x9000 memory, 0x9011 parameter
// - compat mode alarm control suppresses diagnostics
// - word two shows 0x0F02 life, 0x0F04 sync
// - word two shows 0x1001 memory, 0x1002 parameter
// - six status LEDs
// - scaling only with class 4 and scaling on
// - alarm control 0 comms only, 1 encoder faults
// - compatibility setting 0 legacy, 1 none
// - units per revolution 1..physical counts
module enc_scale_diag
    import enc_diag_pkg::*;
#(
    parameter int POS_W = 30,
    parameter int ST_W = 16,
    parameter int VEL_CYCLES = VEL_DEFAULT_CYCLES,
    parameter int LOG_D = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [POS_W-1:0] PHYS_POS,
    input wire logic LIFE_STROBE,
    input wire logic LIFE_VALID,
    input wire logic BUS_CYCLE_FAIL,
    input wire logic NVM_ERROR,
    output logic [31:0] POSITION_WORD_ONE,
    output logic [31:0] POSITION_WORD_TWO,
    output logic [15:0] VELOCITY_WORD_A,
    output logic [31:0] VELOCITY_WORD_B,
    output logic ALARM_VALID,
    output logic [15:0] ALARM_TYPE,
    output logic [5:0] STATUS_LED
);
    localparam int LAW = $clog2(LOG_D);
    localparam logic [POS_W:0] PHYS_TOTAL = {1'b1, {POS_W{1'b0}}};
    localparam logic [ST_W:0] PHYS_CPR = {1'b1, {ST_W{1'b0}}};
    localparam int VCW = $clog2(VEL_CYCLES);

    logic [31:0] ctrl_r; // mode and unit settings
    logic [POS_W:0] range_r; // set total range
    logic [ST_W:0] units_r; // set units per revolution
    logic [7:0] life_lim_r; // tolerated life-sign failures
    logic [FLT_W-1:0] faults_r; // sticky fault bits
    logic [FLT_W-1:0] flt_set; // fault events this cycle
    logic bad_wr; // rejected parameter write or range below units
    // bus data-phase state
    logic [7:0] addr_r;
    logic wr_r;
    logic log_rd_r;
    logic [31:0] rdata_r;
    logic [31:0] rd_nxt;
    logic addr_ok;

    // mode decode
    logic scale_on;
    logic compat;
    logic alarm_en;
    logic [7:0] tel;
    vel_unit_t vel_unit;
    assign scale_on = ctrl_r[CTL_CLASS4] & ctrl_r[CTL_SCALE];
    assign compat = ~ctrl_r[CTL_NOCOMPAT];
    // outside compat mode the alarm channel is always active
    assign alarm_en = ~compat | ctrl_r[CTL_ALARM];
    assign tel = ctrl_r[CTL_TEL_LSB +: 8];
    assign vel_unit = vel_unit_t'(ctrl_r[CTL_VEL_LSB +: 2]);

    // zero-wait slave, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign addr_ok = HSEL & HREADY & HTRANS[1];

    // address phase capture
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            addr_r <= 8'h00;
            wr_r <= 1'b0;
            log_rd_r <= 1'b0;
        end
        else
        begin
            addr_r <= HADDR[7:0];
            wr_r <= addr_ok & HWRITE;
            log_rd_r <= addr_ok & ~HWRITE & (HADDR[7:6] == LOG_REGION);
        end
    end

    // configuration writes; out-of-range values are refused
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            ctrl_r <= CTRL_RESET;
            range_r <= PHYS_TOTAL;
            units_r <= PHYS_CPR;
            life_lim_r <= LIFE_LIM_RESET;
        end
        else if (wr_r)
        begin
            case (addr_r)
                OFS_CTRL: ctrl_r <= HWDATA;
                OFS_RANGE:
                    if (HWDATA >= RANGE_MIN && HWDATA <= 32'(PHYS_TOTAL))
                    begin
                        range_r <= HWDATA[POS_W:0];
                    end
                OFS_UNITS:
                    if (HWDATA >= UNITS_MIN && HWDATA <= 32'(PHYS_CPR))
                    begin
                        units_r <= HWDATA[ST_W:0];
                    end
                OFS_LIFE_LIM:
                    if (HWDATA[7:0] >= LIFE_LIM_MIN && HWDATA[31:8] == 0)
                    begin
                        life_lim_r <= HWDATA[7:0];
                    end
                default: ;
            endcase
        end
    end

    // refused writes and a range written below the units per revolution flag a parameter error
    always_comb
    begin
        bad_wr = 1'b0;
        if (wr_r)
        begin
            case (addr_r)
                OFS_RANGE: bad_wr = HWDATA < RANGE_MIN
                    || HWDATA > 32'(PHYS_TOTAL)
                    || HWDATA < 32'(units_r);
                OFS_UNITS: bad_wr = HWDATA < UNITS_MIN
                    || HWDATA > 32'(PHYS_CPR);
                OFS_LIFE_LIM: bad_wr = HWDATA[7:0] < LIFE_LIM_MIN
                    || HWDATA[31:8] != 0;
                default: bad_wr = 1'b0;
            endcase
        end
    end

    // serial modulo: alternates position job and red-zone job
    div_state_t dv_state_r;
    logic job_red_r; // 1: dividend is last physical position
    logic [POS_W-1:0] dvd_r; // shifting dividend
    logic [POS_W:0] dvs_r; // divisor
    logic [POS_W:0] rem_r;
    logic [POS_W:0] trial;
    logic [POS_W:0] rem_nxt;
    logic [$clog2(POS_W)-1:0] step_r;
    logic [POS_W-1:0] snap_r; // position being reduced
    logic [POS_W-1:0] scaled_r; // scaled position
    logic [POS_W:0] red_size_r; // red zone length
    logic red_r; // position lies in red zone
    logic done;
    logic [POS_W:0] red_calc;

    assign trial = {rem_r[POS_W-1:0], dvd_r[POS_W-1]};
    assign rem_nxt = (trial >= dvs_r) ? trial - dvs_r : trial;
    assign done = dv_state_r == DV_RUN
        && step_r == ($clog2(POS_W))'(POS_W - 1);
    // last remainder plus one, folded back into the range
    assign red_calc = (rem_nxt + 1'b1 == dvs_r) ? '0 : rem_nxt + 1'b1;

    // divider sequencing
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            dv_state_r <= DV_LOAD;
            job_red_r <= 1'b0;
            dvd_r <= '0;
            dvs_r <= '0;
            rem_r <= '0;
            step_r <= '0;
            snap_r <= '0;
        end
        else
        begin
            case (dv_state_r)
                DV_LOAD:
                begin
                    // range is ignored when scaling is off
                    dvs_r <= scale_on ? range_r : PHYS_TOTAL;
                    dvd_r <= job_red_r ? PHYS_TOTAL[POS_W-1:0] - 1'b1
                        : PHYS_POS;
                    if (!job_red_r)
                    begin
                        snap_r <= PHYS_POS;
                    end
                    rem_r <= '0;
                    step_r <= '0;
                    dv_state_r <= DV_RUN;
                end
                DV_RUN:
                begin
                    rem_r <= rem_nxt;
                    dvd_r <= {dvd_r[POS_W-2:0], 1'b0};
                    step_r <= step_r + 1'b1;
                    if (done)
                    begin
                        job_red_r <= ~job_red_r;
                        dv_state_r <= DV_LOAD;
                    end
                end
                default: dv_state_r <= DV_LOAD;
            endcase
        end
    end

    // results: remainder is the scaled value, red-zone flag follows from the snapshot and red zone length
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            scaled_r <= '0;
            red_size_r <= '0;
            red_r <= 1'b0;
        end
        else if (done && job_red_r)
        begin
            red_size_r <= red_calc;
        end
        else if (done)
        begin
            scaled_r <= rem_nxt[POS_W-1:0];
            red_r <= red_size_r != 0
                && {1'b0, snap_r} >= PHYS_TOTAL - red_size_r;
        end
    end

    // life-sign monitoring
    logic [7:0] miss_r; // consecutive misses
    logic [7:0] life_lim; // limit in force
    logic life_over;
    assign life_lim = compat ? life_lim_r : LIFE_LIM_MIN;
    assign life_over = LIFE_STROBE & ~LIFE_VALID
        & ({1'b0, miss_r} + 9'h001 > {1'b0, life_lim});

    // miss counter, saturating, cleared by a good sign
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            miss_r <= 8'h00;
        end
        else if (LIFE_STROBE)
        begin
            if (LIFE_VALID)
            begin
                miss_r <= 8'h00;
            end
            else if (miss_r != 8'hFF)
            begin
                miss_r <= miss_r + 8'h01;
            end
        end
    end

    // fault events; any of them may corrupt the position
    always_comb
    begin
        flt_set = '0;
        flt_set[FLT_LIFE] = life_over;
        flt_set[FLT_SYNC] = BUS_CYCLE_FAIL;
        flt_set[FLT_MEM] = NVM_ERROR;
        flt_set[FLT_PARAM] = bad_wr;
    end

    // sticky faults, write one to clear, a new event wins
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            faults_r <= '0;
        end
        else if (wr_r && addr_r == OFS_FAULTS)
        begin
            faults_r <= (faults_r & ~HWDATA[FLT_W-1:0]) | flt_set;
        end
        else
        begin
            faults_r <= faults_r | flt_set;
        end
    end

    // channel alarms for encoder-specific faults; memory wins a tie
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            ALARM_VALID <= 1'b0;
            ALARM_TYPE <= 16'h0000;
        end
        else
        begin
            ALARM_VALID <= alarm_en & (flt_set[FLT_MEM]
                | (flt_set[FLT_PARAM] & ~faults_r[FLT_PARAM]));
            ALARM_TYPE <= flt_set[FLT_MEM] ? ALM_MEM : ALM_PARAM;
        end
    end

    // diagnosis log, read only through record reads on the bus
    logic [LAW-1:0] log_wp_r;
    logic [7:0] log_cnt_r;
    logic log_we;
    logic [15:0] log_code;
    logic [15:0] log_q;
    logic [FLT_W-1:0] flt_new;
    assign flt_new = flt_set & ~faults_r;
    assign log_we = |flt_new;
    assign log_code = flt_new[FLT_LIFE] ? ERR_LIFE
        : flt_new[FLT_SYNC] ? ERR_SYNC
        : flt_new[FLT_MEM] ? ERR_MEM : ERR_PARAM;

    // log write pointer and entry count
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            log_wp_r <= '0;
            log_cnt_r <= 8'h00;
        end
        else if (log_we)
        begin
            log_wp_r <= log_wp_r + 1'b1;
            log_cnt_r <= log_cnt_r + 8'h01;
        end
    end

    diag_log_mem #(
        .WIDTH(16),
        .DEPTH(LOG_D)
    ) u_log (
        .clk(SYS_CLK),
        .wr_en(log_we),
        .wr_addr(log_wp_r),
        .wr_data(log_code),
        .rd_addr(HADDR[LAW+1:2]),
        .rd_data(log_q)
    );

    // velocity: 100 ms window of position change
    logic [VCW-1:0] vel_cnt_r;
    logic vel_tick;
    logic [POS_W-1:0] vel_prev_r;
    logic signed [47:0] delta;
    logic signed [47:0] vel_calc;
    logic vel_tel;
    logic [31:0] vel_b_r;
    assign vel_tick = vel_cnt_r == VCW'(VEL_CYCLES - 1);
    assign delta = 48'(signed'(PHYS_POS - vel_prev_r));
    assign vel_tel = tel >= TEL_VEL_FIRST && tel <= TEL_VEL_LAST;

    // unit conversion of the window delta
    always_comb
    begin
        case (vel_unit)
            VU_STEPS_S: vel_calc = delta * VEL_PER_S_MUL;
            VU_STEPS_100MS: vel_calc = delta;
            VU_STEPS_10MS: vel_calc = delta / VEL_10MS_DIV;
            VU_RPM: vel_calc = (delta * VEL_RPM_MUL) >>> ST_W;
            default: vel_calc = delta;
        endcase
    end

    // period counter and velocity update
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            vel_cnt_r <= '0;
            vel_prev_r <= '0;
            vel_b_r <= 32'h0000_0000;
        end
        else
        begin
            vel_cnt_r <= vel_tick ? '0 : vel_cnt_r + 1'b1;
            if (vel_tick)
            begin
                vel_prev_r <= PHYS_POS;
                vel_b_r <= vel_tel ? vel_calc[31:0] : 32'h0000_0000;
            end
        end
    end

    // cyclic words and LEDs; word two carries the highest fault
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            POSITION_WORD_ONE <= 32'h0000_0000;
            POSITION_WORD_TWO <= 32'h0000_0000;
            STATUS_LED <= 6'h00;
        end
        else
        begin
            POSITION_WORD_ONE <= 32'(scaled_r);
            if (faults_r[FLT_LIFE])
                POSITION_WORD_TWO <= 32'(ERR_LIFE);
            else if (faults_r[FLT_SYNC])
                POSITION_WORD_TWO <= 32'(ERR_SYNC);
            else if (faults_r[FLT_MEM])
                POSITION_WORD_TWO <= 32'(ERR_MEM);
            else if (faults_r[FLT_PARAM])
                POSITION_WORD_TWO <= 32'(ERR_PARAM);
            else
                POSITION_WORD_TWO <= 32'(scaled_r);
            STATUS_LED <= {faults_r, |faults_r, ~|faults_r};
        end
    end
    assign VELOCITY_WORD_A = vel_b_r[15:0];
    assign VELOCITY_WORD_B = vel_b_r;

    // read mux evaluated in the address phase
    always_comb
    begin
        case (HADDR[7:0])
            OFS_CTRL: rd_nxt = ctrl_r;
            OFS_RANGE: rd_nxt = 32'(range_r);
            OFS_UNITS: rd_nxt = 32'(units_r);
            OFS_LIFE_LIM: rd_nxt = 32'(life_lim_r);
            OFS_FAULTS: rd_nxt = 32'(faults_r);
            // warnings read as zero and unsupported
            OFS_OP_STAT: rd_nxt = {16'h0000, WARN_SUPPORTED, FLT_SUPPORTED,
                4'h0, faults_r};
            OFS_POS: rd_nxt = 32'(scaled_r);
            OFS_VEL: rd_nxt = vel_b_r;
            OFS_RED: rd_nxt = {red_r, 31'(red_size_r)};
            OFS_LOG_CNT: rd_nxt = 32'(log_cnt_r);
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // read data register
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (addr_ok && !HWRITE)
        begin
            rdata_r <= rd_nxt;
        end
    end
    assign HRDATA = log_rd_r ? {16'h0000, log_q} : rdata_r;

    chk_range_bounds: assert property (@(posedge SYS_CLK) disable iff (RST)
        range_r >= RANGE_MIN && range_r <= PHYS_TOTAL)
        else $error("total range outside its limits");
    chk_scale_off: assert property (@(posedge SYS_CLK) disable iff (RST)
        done && !job_red_r && dvs_r == PHYS_TOTAL
        |=> scaled_r == snap_r)
        else $error("unscaled position altered");
    chk_mod_wrap: assert property (@(posedge SYS_CLK) disable iff (RST)
        done && !job_red_r |=> {1'b0, scaled_r} < dvs_r)
        else $error("scaled position not below range");
    chk_life_fault: assert property (@(posedge SYS_CLK) disable iff (RST)
        life_over |=> faults_r[FLT_LIFE] ##1 POSITION_WORD_TWO
        == 32'(ERR_LIFE))
        else $error("life-sign fault not reported");
    chk_life_limit: assert property (@(posedge SYS_CLK) disable iff (RST)
        LIFE_STROBE && !LIFE_VALID && !compat && miss_r == 8'h00
        |=> !faults_r[FLT_LIFE] || $past(faults_r[FLT_LIFE]))
        else $error("first miss faulted outside compat mode");
    chk_alarm_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
        compat && !ctrl_r[CTL_ALARM] |=> !ALARM_VALID)
        else $error("alarm sent while switched off");
    chk_alarm_type: assert property (@(posedge SYS_CLK) disable iff (RST)
        alarm_en && NVM_ERROR |=> ALARM_VALID && ALARM_TYPE == ALM_MEM)
        else $error("memory alarm missing");
    chk_vel_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
        !vel_tick |=> $stable(vel_b_r))
        else $error("velocity changed between periods");
    chk_vel_tel: assert property (@(posedge SYS_CLK) disable iff (RST)
        vel_tick && !vel_tel |=> VELOCITY_WORD_B == 32'h0000_0000)
        else $error("velocity on a telegram without it");
    chk_led_fault: assert property (@(posedge SYS_CLK) disable iff (RST)
        faults_r[FLT_MEM] |=> STATUS_LED[1] && !STATUS_LED[0])
        else $error("fault LED not lit");
endmodule : enc_scale_diag

// >>> verification/plc_model.sv
`timescale 1ns/1ns
// controller side: one life-sign slot per clock while asked
module plc_model (
    input wire logic clk,
    output logic life_strobe,
    output logic life_valid
);
    initial life_strobe = 1'b0; // quiet until asked
    initial life_valid = 1'b0;
    // pattern lsb first, 1 = good sign; valid flips when idle so a
    // stale level never passes for a sign
    task send(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            life_strobe <= 1'b1;
            life_valid <= pat[i];
        end
        @(posedge clk);
        life_strobe <= 1'b0;
        life_valid <= ~life_valid;
    endtask : send
endmodule : plc_model

// >>> verification/encoder_scaling_and_diagnostics_test.sv
`timescale 1ns/1ns
// bench: registers over the bus, life signs from the controller model
module encoder_scaling_and_diagnostics_test
    import enc_diag_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0;
    logic [31:0] HWDATA = 32'h0;
    logic [29:0] PHYS_POS = 30'h0;
    logic BUS_CYCLE_FAIL = 1'b0;
    logic NVM_ERROR = 1'b0;
    logic mv = 1'b0; // ramp the shaft 64 steps a clock
    logic HREADYOUT, HRESP, LIFE_STROBE, LIFE_VALID, ALARM_VALID;
    logic [31:0] HRDATA, POSITION_WORD_ONE, POSITION_WORD_TWO;
    logic [31:0] VELOCITY_WORD_B;
    logic [15:0] VELOCITY_WORD_A, ALARM_TYPE, last_type;
    logic [5:0] STATUS_LED;
    int n_fail = 0;
    int compares = 0;
    int n_alarm = 0;
    // delta of 3200 per period, large enough for a non-zero rpm value
    int vel_exp [4] = '{32000, 3200, 320, 29};
    // short velocity period keeps the run brief
    enc_scale_diag #(.VEL_CYCLES(50)) i_dut (
        .*, .HREADY(HREADYOUT), .HSIZE(3'h2));
    plc_model i_plc (.clk(SYS_CLK), .life_strobe(LIFE_STROBE),
        .life_valid(LIFE_VALID));
    initial forever #4 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (mv) PHYS_POS <= PHYS_POS + 30'h40;
    // count alarm pulses and keep the last type
    always @(posedge SYS_CLK) if (ALARM_VALID === 1'b1) n_alarm++;
    always @(posedge SYS_CLK) if (ALARM_VALID) last_type <= ALARM_TYPE;
    task conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    // one single transfer; either phase may be stretched by the slave
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge SYS_CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        q = HRDATA;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rchk
    // one-clock fault event: sync failure or memory error
    task strike(input logic sync);
        @(posedge SYS_CLK);
        BUS_CYCLE_FAIL <= sync;
        NVM_ERROR <= ~sync;
        @(posedge SYS_CLK);
        BUS_CYCLE_FAIL <= 1'b0;
        NVM_ERROR <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
    endtask : strike
    initial
    begin
        repeat (2) @(posedge SYS_CLK);
        RST <= 1'b0;
        rchk(OFS_CTRL, CTRL_RESET);
        rchk(OFS_RANGE, 32'h4000_0000);
        rchk(OFS_LIFE_LIM, 32'h1);
        rchk(OFS_OP_STAT, 32'h0000_0F00);
        rchk(8'h30, 32'h0);
        chk({26'h0, STATUS_LED}, 32'h1);
        chk({31'h0, HRESP}, 32'h0);
        $display("reset test done");
        // refused settings keep the old value and flag a fault
        wr(OFS_RANGE, 32'h1);
        rchk(OFS_RANGE, 32'h4000_0000);
        rchk(OFS_FAULTS, 32'h8);
        // the new fault lands in the first log entry
        rchk(8'h40, {16'h0, ERR_PARAM});
        rchk(OFS_LOG_CNT, 32'h1);
        chk(POSITION_WORD_TWO, {16'h0, ERR_PARAM});
        wr(OFS_LIFE_LIM, 32'h0);
        rchk(OFS_LIFE_LIM, 32'h1);
        wr(OFS_LIFE_LIM, 32'hFF);
        rchk(OFS_LIFE_LIM, 32'hFF);
        wr(OFS_FAULTS, 32'hF);
        // memory error alarms only with the alarm channel on
        strike(1'b0);
        chk(POSITION_WORD_TWO, {16'h0, ERR_MEM});
        chk(32'(n_alarm), 32'h0);
        wr(OFS_CTRL, 32'h5109);
        strike(1'b0);
        chk(32'(n_alarm), 32'h1);
        chk({16'h0, last_type}, {16'h0, ALM_MEM});
        // refused units value: a new parameter error alarms too
        wr(OFS_UNITS, 32'h0);
        repeat (2) @(posedge SYS_CLK);
        chk(32'(n_alarm), 32'h2);
        chk({16'h0, last_type}, {16'h0, ALM_PARAM});
        wr(OFS_FAULTS, 32'hF);
        strike(1'b1);
        chk(POSITION_WORD_TWO, {16'h0, ERR_SYNC});
        chk({26'h0, STATUS_LED}, 32'h0A);
        wr(OFS_FAULTS, 32'hF);
        $display("fault test done");
        // limit 255 holds in compatibility mode, 1 outside it
        i_plc.send(8'h04, 3);
        rchk(OFS_FAULTS, 32'h0);
        wr(OFS_CTRL, 32'h5105);
        i_plc.send(8'h05, 4);
        rchk(OFS_FAULTS, 32'h0);
        i_plc.send(8'h00, 1);
        repeat (3) @(posedge SYS_CLK);
        chk(POSITION_WORD_TWO, {16'h0, ERR_LIFE});
        chk({26'h0, STATUS_LED}, 32'h06);
        i_plc.send(8'h01, 1);
        wr(OFS_FAULTS, 32'hF);
        $display("life sign test done");
        // range leaving a red zone: top of travel, then zero
        PHYS_POS <= 30'h3FFF_FFFF;
        wr(OFS_CTRL, 32'h5103);
        wr(OFS_RANGE, 32'h1A5C_0000);
        // a fresh position sample stands in for the preset after the change
        repeat (400) @(posedge SYS_CLK);
        rchk(OFS_POS, 32'h0B47_FFFF);
        rchk(OFS_RED, 32'h8B48_0000);
        chk(POSITION_WORD_TWO, 32'h0B47_FFFF);
        PHYS_POS <= 30'h0;
        repeat (400) @(posedge SYS_CLK);
        rchk(OFS_POS, 32'h0);
        rchk(OFS_RED, 32'h0B48_0000);
        PHYS_POS <= 30'h3FFF_FFFF;
        for (int i = 0; i < 2; i++)
        begin
            wr(OFS_CTRL, 32'h5101 + 32'(i));
            repeat (400) @(posedge SYS_CLK);
            chk(POSITION_WORD_ONE, 32'h3FFF_FFFF);
        end
        $display("scaling test done");
        // velocity: none on telegram 81, each unit on one of telegrams 82..84
        PHYS_POS <= 30'h0;
        @(posedge SYS_CLK);
        mv <= 1'b1;
        repeat (120) @(posedge SYS_CLK);
        chk(VELOCITY_WORD_B, 32'h0);
        for (int u = 0; u < 4; u++)
        begin
            // telegrams 82, 83 and 84 all carry the velocity
            wr(OFS_CTRL, 32'h5201 + 32'(u * 16 + (u % 3) * 256));
            repeat (120) @(posedge SYS_CLK);
            chk(VELOCITY_WORD_B, 32'(vel_exp[u]));
            chk({16'h0, VELOCITY_WORD_A}, 32'(vel_exp[u]));
        end
        $display("velocity test done");
        conclude();
    end
    // tests take about 2300 clocks; this cuts a hang short
    initial
    begin
        #80000;
        n_fail++;
        conclude();
    end
endmodule : encoder_scaling_and_diagnostics_test
